/* hw/lpa_pkg.sv */
// constants, control layout and register map of the lookahead parallel adder
package lpa_pkg;
   // ------------------------------------------------------------
   // datapath geometry
   // ------------------------------------------------------------
   localparam int POS_N = 60;
   localparam int GRP_W = 4;
   localparam int GRP_N = 15;
   localparam int SEC_N = 4;
   localparam int GRP_PER_SEC = 4;
   localparam int SHIFT_D = 4;
   localparam int HI_W = 28;
   localparam int ADR_W = 8;
   // ------------------------------------------------------------
   // register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_A_LO = 8'h00;
   localparam logic [7:0] ADR_A_HI = 8'h04;
   localparam logic [7:0] ADR_B_LO = 8'h08;
   localparam logic [7:0] ADR_B_HI = 8'h0C;
   localparam logic [7:0] ADR_CTRL = 8'h10;
   localparam logic [7:0] ADR_STAT = 8'h14;
   localparam logic [7:0] ADR_R_LO = 8'h18;
   localparam logic [7:0] ADR_R_HI = 8'h1C;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int OP_LSB = 0;
   localparam int OP_W = 3;
   localparam int SH_LSB = 4;
   localparam int SH_W = 2;
   localparam int FORCE_BIT = 8;
   localparam int HOT_BIT = 9;
   localparam int HOLD_BIT = 10;
   localparam int GO_BIT = 16;
   localparam int ST_BUSY = 0;
   localparam int ST_COUT = 1;
   localparam int ST_BADSH = 2;
   localparam int ST_FULL = 3;
   localparam int RES_PAR_BIT = 28;
   // ------------------------------------------------------------
   // codes and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] OP_ADD = 3'h0;
   localparam logic [2:0] OP_AND = 3'h1;
   localparam logic [2:0] OP_OR = 3'h2;
   localparam logic [2:0] OP_XOR = 3'h3;
   localparam logic [2:0] OP_PASS = 3'h4;
   localparam logic [1:0] SH_ZERO = 2'h0;
   localparam logic [1:0] SH_LEFT = 2'h1;
   localparam logic [1:0] SH_RIGHT = 2'h2;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   typedef struct packed {
      logic hold;
      logic hotCarry;
      logic forceOnes;
      logic [1:0] shift;
      logic [2:0] op;
   } lpa_ctrl_t;
   localparam lpa_ctrl_t CTRL_RST = '{hold: 1'b0, hotCarry: 1'b0, forceOnes: 1'b0, shift: SH_ZERO, op: OP_ADD};
   typedef enum logic [2:0] {LPA_IDLE, LPA_LOAD, LPA_SAMPLE, LPA_EXT, LPA_HOLD} lpa_state_t;
endpackage

/* hw/lpa_adder.sv */
// lookahead parallel adder with latch-shifter behind a wishbone slave
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module lpa_adder (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [lpa_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // adder latch and state
   output logic [0:lpa_pkg::POS_N-1] sumLatch,
   output logic sumParity,
   output logic busy
);
   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return m;
   endfunction

   // low-order position of group k, groups counted from the low end
   function automatic int lowPos(input int k);
      return lpa_pkg::POS_N - 1 - lpa_pkg::GRP_W * k;
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [0:lpa_pkg::POS_N-1] opA_reg, opB_reg, resSum_reg;
   logic [0:lpa_pkg::POS_N-1] aIn, bitT, bitC, halfS, carryIn, fullS, resSel, shifted;
   logic [0:lpa_pkg::GRP_N-1] grpT, grpC, cig, predC;
   logic [0:lpa_pkg::SEC_N-1] secT, secC;
   logic [0:lpa_pkg::SEC_N] cis;
   lpa_pkg::lpa_ctrl_t cfg_reg;
   lpa_pkg::lpa_state_t state_reg;
   logic resPar_reg, cout_reg, badSh_reg;
   logic gc, gt, sc, st, run, tr, cinEff, okShift;
   logic [31:0] rd, wrMerged;
   logic acc, wrEn, go;
   logic [lpa_pkg::POS_N:0] refSum;

   // ------------------------------------------------------------
   // half-adders, position 0 most significant
   // ------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < lpa_pkg::POS_N; p++) begin
         aIn[p] = opA_reg[p] | cfg_reg.forceOnes;
         bitT[p] = aIn[p] | opB_reg[p];
         bitC[p] = aIn[p] & opB_reg[p];
         halfS[p] = aIn[p] ^ opB_reg[p];
      end
   end

   // ------------------------------------------------------------
   // group level: incoming data only, no propagated carry
   // ------------------------------------------------------------
   always_comb begin
      grpT = '0;
      grpC = '0;
      gc = 1'b0;
      gt = 1'b1;
      for (int k = 0; k < lpa_pkg::GRP_N; k++) begin
         gc = 1'b0;
         gt = 1'b1;
         for (int j = 0; j < lpa_pkg::GRP_W; j++) begin
            gc = bitC[lowPos(k) - j] | (bitT[lowPos(k) - j] & gc);
            gt = gt & bitT[lowPos(k) - j];
         end
         grpC[k] = gc;
         grpT[k] = gt;
      end
   end

   // ------------------------------------------------------------
   // section level and carry into section
   // ------------------------------------------------------------
   always_comb begin
      secT = '0;
      secC = '0;
      cis = '0;
      sc = 1'b0;
      st = 1'b1;
      cis[0] = cfg_reg.hotCarry;
      for (int s = 0; s < lpa_pkg::SEC_N; s++) begin
         sc = 1'b0;
         st = 1'b1;
         for (int g = 0; g < lpa_pkg::GRP_PER_SEC; g++) begin
            if (s * lpa_pkg::GRP_PER_SEC + g < lpa_pkg::GRP_N) begin
               sc = grpC[s*lpa_pkg::GRP_PER_SEC+g] | (grpT[s*lpa_pkg::GRP_PER_SEC+g] & sc);
               st = st & grpT[s*lpa_pkg::GRP_PER_SEC+g];
            end
         end
         secC[s] = sc;
         secT[s] = st;
         cis[s+1] = secC[s] | (secT[s] & cis[s]);
      end
   end

   // ------------------------------------------------------------
   // carry into group, carry into bit, full sum
   // ------------------------------------------------------------
   // the in-group actual path is at most three positions deep, so the
   // sum settles without any pass through the latches
   always_comb begin
      cig = '0;
      predC = '0;
      carryIn = '0;
      fullS = '0;
      run = 1'b0;
      tr = 1'b1;
      cinEff = 1'b0;
      for (int k = 0; k < lpa_pkg::GRP_N; k++) begin
         if (k % lpa_pkg::GRP_PER_SEC == 0) begin
            cig[k] = cis[k/lpa_pkg::GRP_PER_SEC];
         end else begin
            cig[k] = grpC[k-1] | (grpT[k-1] & cig[k-1]);
         end
         if (k == 0) begin
            predC[k] = cig[k];
            cinEff = predC[k];
         end else begin
            predC[k] = cig[k] & ~grpC[k-1];
            cinEff = grpC[k-1] | predC[k];
         end
         run = 1'b0;
         tr = 1'b1;
         for (int j = 0; j < lpa_pkg::GRP_W; j++) begin
            carryIn[lowPos(k)-j] = run | (tr & cinEff);
            fullS[lowPos(k)-j] = carryIn[lowPos(k)-j] ^ halfS[lowPos(k)-j];
            run = bitC[lowPos(k)-j] | (bitT[lowPos(k)-j] & run);
            tr = tr & bitT[lowPos(k)-j];
         end
      end
   end

   // ------------------------------------------------------------
   // function select and latch-shifter
   // ------------------------------------------------------------
   always_comb begin
      case (cfg_reg.op)
         lpa_pkg::OP_AND: resSel = bitC;
         lpa_pkg::OP_OR: resSel = bitT;
         lpa_pkg::OP_XOR: resSel = halfS;
         lpa_pkg::OP_PASS: resSel = aIn;
         default: resSel = fullS;
      endcase
   end

   always_comb begin
      shifted = '0;
      okShift = 1'b1;
      case (cfg_reg.shift)
         lpa_pkg::SH_ZERO: shifted = resSel;
         lpa_pkg::SH_LEFT: shifted[0:lpa_pkg::POS_N-1-lpa_pkg::SHIFT_D] = resSel[lpa_pkg::SHIFT_D:lpa_pkg::POS_N-1];
         lpa_pkg::SH_RIGHT: shifted[lpa_pkg::SHIFT_D:lpa_pkg::POS_N-1] = resSel[0:lpa_pkg::POS_N-1-lpa_pkg::SHIFT_D];
         default: okShift = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // sequencer: load, sample, extended reset, optional hold
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= lpa_pkg::LPA_IDLE;
      end else begin
         case (state_reg)
            lpa_pkg::LPA_IDLE: if (go) state_reg <= lpa_pkg::LPA_LOAD;
            lpa_pkg::LPA_LOAD: state_reg <= okShift ? lpa_pkg::LPA_SAMPLE : lpa_pkg::LPA_IDLE;
            lpa_pkg::LPA_SAMPLE: state_reg <= lpa_pkg::LPA_EXT;
            lpa_pkg::LPA_EXT: state_reg <= cfg_reg.hold ? lpa_pkg::LPA_HOLD : lpa_pkg::LPA_IDLE;
            default: state_reg <= lpa_pkg::LPA_IDLE;
         endcase
      end
   end

   // latch reset waits for the extended clock so the result register and
   // the parity check see a stable sum
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sumLatch <= '0;
         sumParity <= 1'b0;
      end else if (state_reg == lpa_pkg::LPA_LOAD && okShift) begin
         sumLatch <= shifted;
         sumParity <= ~^shifted;
      end else if ((state_reg == lpa_pkg::LPA_EXT && !cfg_reg.hold) || state_reg == lpa_pkg::LPA_HOLD) begin
         sumLatch <= '0;
         sumParity <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         resSum_reg <= '0;
         resPar_reg <= 1'b0;
      end else if (state_reg == lpa_pkg::LPA_SAMPLE) begin
         resSum_reg <= sumLatch;
         resPar_reg <= sumParity;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cout_reg <= 1'b0;
      end else if (state_reg == lpa_pkg::LPA_LOAD && okShift) begin
         cout_reg <= cis[lpa_pkg::SEC_N];
      end
   end

   // a new bad code wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         badSh_reg <= 1'b0;
      end else if (state_reg == lpa_pkg::LPA_LOAD && !okShift) begin
         badSh_reg <= 1'b1;
      end else if (wrEn && adr_i == lpa_pkg::ADR_STAT && wrMerged[lpa_pkg::ST_BADSH]) begin
         badSh_reg <= 1'b0;
      end
   end

   assign busy = (state_reg != lpa_pkg::LPA_IDLE);

   // ------------------------------------------------------------
   // wishbone slave: ack one cycle after the strobe, write at ack edge
   // ------------------------------------------------------------
   assign acc = cyc_i & stb_i & ~ack_o;
   assign wrEn = cyc_i & stb_i & we_i & ack_o;
   assign wrMerged = mergeWord(rd, dat_i, sel_i);
   assign go = wrEn && adr_i == lpa_pkg::ADR_CTRL && wrMerged[lpa_pkg::GO_BIT];

   always_comb begin
      rd = lpa_pkg::WORD_ZERO;
      case (adr_i)
         lpa_pkg::ADR_A_LO: rd = opA_reg[lpa_pkg::HI_W:lpa_pkg::POS_N-1];
         lpa_pkg::ADR_A_HI: rd[lpa_pkg::HI_W-1:0] = opA_reg[0:lpa_pkg::HI_W-1];
         lpa_pkg::ADR_B_LO: rd = opB_reg[lpa_pkg::HI_W:lpa_pkg::POS_N-1];
         lpa_pkg::ADR_B_HI: rd[lpa_pkg::HI_W-1:0] = opB_reg[0:lpa_pkg::HI_W-1];
         lpa_pkg::ADR_CTRL: begin
            rd[lpa_pkg::OP_LSB +: lpa_pkg::OP_W] = cfg_reg.op;
            rd[lpa_pkg::SH_LSB +: lpa_pkg::SH_W] = cfg_reg.shift;
            rd[lpa_pkg::FORCE_BIT] = cfg_reg.forceOnes;
            rd[lpa_pkg::HOT_BIT] = cfg_reg.hotCarry;
            rd[lpa_pkg::HOLD_BIT] = cfg_reg.hold;
         end
         lpa_pkg::ADR_STAT: begin
            rd[lpa_pkg::ST_BUSY] = busy;
            rd[lpa_pkg::ST_COUT] = cout_reg;
            rd[lpa_pkg::ST_BADSH] = badSh_reg;
            rd[lpa_pkg::ST_FULL] = (state_reg == lpa_pkg::LPA_SAMPLE) || (state_reg == lpa_pkg::LPA_EXT)
               || (state_reg == lpa_pkg::LPA_HOLD);
         end
         lpa_pkg::ADR_R_LO: rd = resSum_reg[lpa_pkg::HI_W:lpa_pkg::POS_N-1];
         lpa_pkg::ADR_R_HI: begin
            rd[lpa_pkg::HI_W-1:0] = resSum_reg[0:lpa_pkg::HI_W-1];
            rd[lpa_pkg::RES_PAR_BIT] = resPar_reg;
         end
         default: rd = lpa_pkg::WORD_ZERO;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_o <= 1'b0;
         dat_o <= lpa_pkg::WORD_ZERO;
      end else begin
         ack_o <= acc;
         if (acc) begin
            dat_o <= rd;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         opA_reg <= '0;
         opB_reg <= '0;
      end else if (wrEn) begin
         case (adr_i)
            lpa_pkg::ADR_A_LO: opA_reg[lpa_pkg::HI_W:lpa_pkg::POS_N-1] <= wrMerged;
            lpa_pkg::ADR_A_HI: opA_reg[0:lpa_pkg::HI_W-1] <= wrMerged[lpa_pkg::HI_W-1:0];
            lpa_pkg::ADR_B_LO: opB_reg[lpa_pkg::HI_W:lpa_pkg::POS_N-1] <= wrMerged;
            lpa_pkg::ADR_B_HI: opB_reg[0:lpa_pkg::HI_W-1] <= wrMerged[lpa_pkg::HI_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= lpa_pkg::CTRL_RST;
      end else if (wrEn && adr_i == lpa_pkg::ADR_CTRL) begin
         cfg_reg.op <= wrMerged[lpa_pkg::OP_LSB +: lpa_pkg::OP_W];
         cfg_reg.shift <= wrMerged[lpa_pkg::SH_LSB +: lpa_pkg::SH_W];
         cfg_reg.forceOnes <= wrMerged[lpa_pkg::FORCE_BIT];
         cfg_reg.hotCarry <= wrMerged[lpa_pkg::HOT_BIT];
         cfg_reg.hold <= wrMerged[lpa_pkg::HOLD_BIT];
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   assign refSum = {1'b0, aIn} + {1'b0, opB_reg} + (lpa_pkg::POS_N+1)'(cfg_reg.hotCarry);

   AST_BIT_TRANSMIT: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_LOAD) |-> (bitT == (aIn | opB_reg)))
      else $error("bit transmit differs from operand or");
   AST_BIT_CARRY: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_LOAD) |-> ((bitC & ~(aIn & opB_reg)) == '0 && (bitC | ~(aIn & opB_reg)) == '1))
      else $error("bit carry differs from operand and");
   AST_HALF_SUM: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_LOAD) |-> (halfS == (bitT & ~bitC)))
      else $error("half sum not transmit without carry");
   AST_FORCE_ONES: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_LOAD && cfg_reg.forceOnes) |-> (&aIn))
      else $error("force ones left an a-side bit low");
   AST_ADD_SUM: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_LOAD && cfg_reg.op == lpa_pkg::OP_ADD && cfg_reg.shift == lpa_pkg::SH_ZERO)
      |=> (sumLatch == $past(refSum[lpa_pkg::POS_N-1:0])) && (cout_reg == $past(refSum[lpa_pkg::POS_N])))
      else $error("latched sum or carry out wrong");
   AST_SHIFT_LEFT: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_LOAD && cfg_reg.shift == lpa_pkg::SH_LEFT)
      |=> (sumLatch[0:lpa_pkg::POS_N-1-lpa_pkg::SHIFT_D] == $past(resSel[lpa_pkg::SHIFT_D:lpa_pkg::POS_N-1]))
      && (sumLatch[lpa_pkg::POS_N-lpa_pkg::SHIFT_D:lpa_pkg::POS_N-1] == '0))
      else $error("left shift misplaced the sum");
   AST_LATCH_KEEP: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_LOAD && okShift) |=> ##1 ($stable(sumLatch) && resSum_reg == $past(sumLatch)))
      else $error("latch changed before the result was sampled");
   AST_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_EXT && cfg_reg.hold) |=> $stable(sumLatch) ##1 (sumLatch == '0))
      else $error("hold did not keep the latch one extra cycle");
   AST_BAD_SHIFT: assert property (@(posedge mclk) disable iff (!resetn)
      (state_reg == lpa_pkg::LPA_LOAD && !okShift) |=> badSh_reg && $stable(sumLatch) && !busy)
      else $error("illegal shift code loaded the latch");
endmodule

/* bench/lpa_ctl_model.sv */
// wishbone master standing in for the microprogram controller
`timescale 1ns/1ps
module lpa_ctl_model (
   // clock
   input wire logic mclk,
   // wishbone master side
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [lpa_pkg::ADR_W-1:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   input wire logic [31:0] datIn,
   input wire logic ack
);
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0000_0000;
   end
   // ------------------------------
   // single classic cycle
   // ------------------------------
   // ack and read data are taken at the rising edge that samples ack high
   task automatic wbAccess(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      sel <= 4'hF;
      dat <= d;
      @(posedge mclk);
      while (ack !== 1'b1) @(posedge mclk);
      q = datIn;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // released bus shows a changing pattern, not the last word
      dat <= ~d;
   endtask
endmodule

/* bench/lpa_adder_tb.sv */
// self-checking bench for the lookahead parallel adder
`timescale 1ns/1ps
module lpa_adder_tb;
   typedef struct packed {
      logic [2:0] op;
      logic [1:0] sh;
      logic frc;
      logic hot;
      logic hold;
      logic [59:0] a;
      logic [59:0] b;
   } lpa_row_t;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic cyc, stb, we, ack, sumParity, busy;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] datW, datR, q;
   logic [0:59] sumLatch;
   int failCount = 0;
   int totalChecks = 0;
   lpa_row_t rows [9];
   always #12.5 mclk = ~mclk;
   lpa_adder i_lpa_adder (.mclk(mclk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack), .sumLatch(sumLatch), .sumParity(sumParity), .busy(busy));
   lpa_ctl_model i_lpa_ctl_model (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(datW),
      .datIn(datR), .ack(ack));
   // ------------------------------
   // compare and bus helpers
   // ------------------------------
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkLatch(input logic [59:0] got, input logic [59:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      i_lpa_ctl_model.wbAccess(1'b1, a, d, dummy);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      i_lpa_ctl_model.wbAccess(1'b0, a, 32'h0000_0000, d);
   endtask
   task automatic printVerdict;
      if (failCount == 0 && totalChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ------------------------------
   // one operation from a table row
   // ------------------------------
   task automatic runRow(input lpa_row_t r);
      logic [59:0] av, v;
      logic [60:0] s;
      logic [31:0] w, m;
      av = r.frc ? {60{1'b1}} : r.a;
      s = {1'b0, av} + {1'b0, r.b} + {60'h000_0000_0000_0000, r.hot};
      case (r.op)
         lpa_pkg::OP_AND: v = av & r.b;
         lpa_pkg::OP_OR: v = av | r.b;
         lpa_pkg::OP_XOR: v = av ^ r.b;
         lpa_pkg::OP_PASS: v = av;
         default: v = s[59:0];
      endcase
      // vacated places fill with zero
      if (r.sh == lpa_pkg::SH_LEFT) v = v << 4;
      else if (r.sh == lpa_pkg::SH_RIGHT) v = v >> 4;
      w = 32'h0000_0000;
      w[lpa_pkg::GO_BIT] = 1'b1;
      w[lpa_pkg::HOLD_BIT] = r.hold;
      w[lpa_pkg::HOT_BIT] = r.hot;
      w[lpa_pkg::FORCE_BIT] = r.frc;
      w[lpa_pkg::SH_LSB +: 2] = r.sh;
      w[lpa_pkg::OP_LSB +: 3] = r.op;
      wr(lpa_pkg::ADR_A_LO, r.a[31:0]);
      wr(lpa_pkg::ADR_A_HI, {4'h0, r.a[59:32]});
      wr(lpa_pkg::ADR_B_LO, r.b[31:0]);
      wr(lpa_pkg::ADR_B_HI, {4'h0, r.b[59:32]});
      wr(lpa_pkg::ADR_CTRL, w);
      repeat (2) @(posedge mclk);
      #1;
      chkLatch(sumLatch, v);
      chkWord({31'h0000_0000, busy}, 32'h0000_0001);
      chkWord({31'h0000_0000, sumParity}, {31'h0000_0000, ~^v});
      @(posedge mclk);
      #1;
      chkLatch(sumLatch, r.hold ? v : 60'h000_0000_0000_0000);
      if (r.hold) begin
         @(posedge mclk);
         #1;
         chkLatch(sumLatch, 60'h000_0000_0000_0000);
      end
      rd(lpa_pkg::ADR_R_LO, q);
      chkWord(q, v[31:0]);
      rd(lpa_pkg::ADR_R_HI, q);
      chkWord(q, {3'h0, ~^v, v[59:32]});
      rd(lpa_pkg::ADR_STAT, q);
      // carry out only means something for an add
      m = (r.op == lpa_pkg::OP_ADD) ? 32'h0000_0007 : 32'h0000_0005;
      chkWord(q & m, {29'h0000_0000, 1'b0, s[60], 1'b0} & m);
   endtask
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      rows[0] = '{3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 60'hFFF_FFFF_FFFF_FFFF, 60'h000_0000_0000_0001};
      rows[1] = '{3'h0, 2'h0, 1'b0, 1'b1, 1'b0, 60'h123_4567_89AB_CDEF, 60'h0ED_CBA9_8765_4320};
      rows[2] = '{3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 60'h000_0000_0000_00F8, 60'h000_0000_0000_0008};
      rows[3] = '{3'h1, 2'h0, 1'b0, 1'b0, 1'b0, 60'hF0F_0F0F_0F0F_0F0F, 60'hFF0_0FF0_0FF0_0FF0};
      rows[4] = '{3'h2, 2'h0, 1'b0, 1'b0, 1'b0, 60'hF0F_0F0F_0F0F_0F0F, 60'hFF0_0FF0_0FF0_0FF0};
      rows[5] = '{3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 60'hF0F_0F0F_0F0F_0F0F, 60'hFF0_0FF0_0FF0_0FF0};
      rows[6] = '{3'h4, 2'h1, 1'b0, 1'b0, 1'b0, 60'hA5A_5A5A_5A5A_5A5A, 60'h000_0000_0000_0000};
      rows[7] = '{3'h0, 2'h2, 1'b0, 1'b0, 1'b1, 60'h800_0000_0000_0001, 60'h0FF_0000_0000_0003};
      rows[8] = '{3'h0, 2'h0, 1'b1, 1'b1, 1'b0, 60'h000_0000_0000_1234, 60'h000_0000_0000_0000};
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      chkLatch(sumLatch, 60'h000_0000_0000_0000);
      chkWord({30'h0000_0000, sumParity, busy}, 32'h0000_0000);
      rd(lpa_pkg::ADR_CTRL, q);
      chkWord(q, 32'h0000_0000);
      // result words are read-only
      wr(lpa_pkg::ADR_R_LO, 32'hFFFF_FFFF);
      rd(lpa_pkg::ADR_R_LO, q);
      chkWord(q, 32'h0000_0000);
      rd(8'h20, q);
      chkWord(q, 32'h0000_0000);
      foreach (rows[i]) runRow(rows[i]);
      // go is a pulse and never reads back
      rd(lpa_pkg::ADR_CTRL, q);
      chkWord(q & 32'h0001_0000, 32'h0000_0000);
      // illegal shift code must not load the latch
      wr(lpa_pkg::ADR_CTRL, 32'h0001_0030);
      repeat (2) @(posedge mclk);
      #1;
      chkLatch(sumLatch, 60'h000_0000_0000_0000);
      chkWord({31'h0000_0000, busy}, 32'h0000_0000);
      rd(lpa_pkg::ADR_STAT, q);
      chkWord(q & 32'h0000_0005, 32'h0000_0004);
      wr(lpa_pkg::ADR_STAT, 32'h0000_0004);
      rd(lpa_pkg::ADR_STAT, q);
      chkWord(q & 32'h0000_0004, 32'h0000_0000);
      printVerdict;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      failCount++;
      printVerdict;
   end
endmodule
